// ==== include/wls_pkg.sv ====
/*
 * shared constants and types for the wake level / gpio status register bank.
 * assumes a 7-bit register address from the spi frame decoder and 8-bit data.
 */
package wls_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [6:0] WLS_ADDR_WAKE_SRC_1 = 7'h47;
  localparam logic [6:0] WLS_ADDR_INPUT_LVL = 7'h48;
  localparam logic [6:0] WLS_ADDR_SW_OVERCUR = 7'h54;
  localparam logic [6:0] WLS_ADDR_SW_OPEN_LOAD = 7'h55;

  // ****************************************
  // field positions
  // ****************************************
  localparam int WLS_BIT_GPIO_WAKE = 4;
  localparam int WLS_BIT_DEV_MODE = 7;
  localparam int WLS_BIT_INT_PULLUP = 6;
  localparam int WLS_BIT_PIN_LEVEL = 4;
  localparam int WLS_BIT_WAKE_LVL = 0;
  localparam int WLS_BIT_OC = 6;
  localparam int WLS_BIT_OL = 6;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] WLS_RST_STATUS = 8'h00;
  localparam logic WLS_RST_LEVEL = 1'b0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    WLS_MODE_NORMAL, WLS_MODE_STOP, WLS_MODE_INIT, WLS_MODE_RESTART,
    WLS_MODE_SLEEP, WLS_MODE_FAILSAFE
  } wls_mode_type;

  typedef enum logic [2:0] {
    WLS_GPIO_OFF, WLS_GPIO_FAIL_OUT, WLS_GPIO_WAKE_IN, WLS_GPIO_LOW_SIDE,
    WLS_GPIO_HIGH_SIDE
  } wls_gpio_cfg_type;

endpackage : wls_pkg

// ==== include/wls_lvl_if.sv ====
/*
 * carrier between the top and the level sampler.
 * assumes one clock domain; the top drives the controls, the sampler the levels.
 */
`timescale 1ns/10ps
interface wls_lvl_if;
  import wls_pkg::*;
  logic wake_pin;
  logic gpio_pin;
  logic wake_sample;
  logic gpio_sample;
  logic wake_en;
  logic gpio_en;
  logic hv_meas;
  logic wake_input_level;
  logic general_pin_level;
  modport ctrl (
    output wake_pin, gpio_pin, wake_sample, gpio_sample, wake_en, gpio_en, hv_meas,
    input wake_input_level, general_pin_level
  );
  modport lvl (
    input wake_pin, gpio_pin, wake_sample, gpio_sample, wake_en, gpio_en, hv_meas,
    output wake_input_level, general_pin_level
  );
endinterface : wls_lvl_if

// ==== verilog/wls_level_sampler.sv ====
/*
 * level holder for the wake input and general pin level bits.
 * assumes the top has already folded mode, cyclic sense and config into the strobes.
 */
`timescale 1ns/10ps
module wls_level_sampler
  import wls_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // level port
  wls_lvl_if.lvl lvl
);

  logic wake_lvl_ff;
  logic general_pin_level_ff;
  logic nxt_wake_lvl;
  logic nxt_general_pin_level;

  // measurement forces both to reset, else refresh on strobe
  always_comb begin
    nxt_wake_lvl = wake_lvl_ff;
    nxt_general_pin_level = general_pin_level_ff;
    if (lvl.hv_meas) begin
      nxt_wake_lvl = WLS_RST_LEVEL;
      nxt_general_pin_level = WLS_RST_LEVEL;
    end else begin
      // disabled function keeps the old value
      if (lvl.wake_en && lvl.wake_sample) begin
        nxt_wake_lvl = lvl.wake_pin;
      end
      if (lvl.gpio_en && lvl.gpio_sample) begin
        nxt_general_pin_level = lvl.gpio_pin;
      end
    end
  end

  // level registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_lvl_ff <= WLS_RST_LEVEL;
      general_pin_level_ff <= WLS_RST_LEVEL;
    end else begin
      wake_lvl_ff <= nxt_wake_lvl;
      general_pin_level_ff <= nxt_general_pin_level;
    end
  end

  assign lvl.wake_input_level = wake_lvl_ff;
  assign lvl.general_pin_level = general_pin_level_ff;

endmodule : wls_level_sampler

// ==== verilog/wls_status_regs.sv ====
/*
 * wake source, input level, overcurrent and open-load status registers.
 * assumes a spi frame decoder that presents a 7-bit address and a clear strobe
 * for one cycle, all synchronous to ref_clk_i.
 */
// Function
// - set gpio wake flag on gpio wake event in wake input config, hold until cleared
// - reserved bits in all four registers read zero
// - input level bit 7 shows development mode pin state
// - input level bit 6 shows interrupt pin pull-up strap
// - bit 4 gives gpio level, bit 0 wake input level
// - levels refresh in normal, stop, init and restart modes
// - under cyclic sense or wake, the wake level refreshes only after each sample
// - gpio level refreshes only as wake/low-side/high-side without cyclic sense
// - fail output state goes to failure flag, not gpio level bit
// - disabled wake or gpio function leaves its level bit unchanged
// - hv measurement enabled stops refresh and forces both levels to reset
// - overcurrent flag latches in low-side or high-side switch config
// - one overcurrent flag serves whichever switch config is active
// - overcurrent flag survives disable/reconfig; controller clears it
// - open-load flag latches in high-side switch config
// - latched flags never clear by themselves, only by controller or reset
`timescale 1ns/10ps
module wls_status_regs
  import wls_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register access from the spi frame decoder
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_clear_i,
  output logic [7:0] reg_rdata_o,
  // device state
  input wire wls_mode_type op_mode_i,
  input wire wls_gpio_cfg_type gpio_cfg_i,
  input wire logic wake_enable_i,
  input wire logic cyclic_active_i,
  input wire logic cyclic_sample_i,
  input wire logic hv_measure_enable_i,
  // pins and straps
  input wire logic hv_wake_input_i,
  input wire logic gpio_pin_i,
  input wire logic development_mode_pin_state_i,
  input wire logic interrupt_pin_pullup_strap_i,
  // events
  input wire logic gpio_wake_event_i,
  input wire logic switch_overcurrent_i,
  input wire logic switch_open_load_i,
  // fail output state towards the device status failure flag
  output logic fail_output_failure_o
);

  // ****************************************
  // decoding helpers
  // ****************************************

  // modes in which the level register is live
  function automatic logic mode_refreshes(input wls_mode_type m);
    mode_refreshes = (m == WLS_MODE_NORMAL) || (m == WLS_MODE_STOP) ||
                     (m == WLS_MODE_INIT) || (m == WLS_MODE_RESTART);
  endfunction : mode_refreshes

  // gpio configurations that own a level bit
  function automatic logic gpio_has_level(input wls_gpio_cfg_type c);
    gpio_has_level = (c == WLS_GPIO_WAKE_IN) || (c == WLS_GPIO_LOW_SIDE) ||
                     (c == WLS_GPIO_HIGH_SIDE);
  endfunction : gpio_has_level

  function automatic logic is_switch(input wls_gpio_cfg_type c);
    is_switch = (c == WLS_GPIO_LOW_SIDE) || (c == WLS_GPIO_HIGH_SIDE);
  endfunction : is_switch

  // ****************************************
  // level path
  // ****************************************
  wls_lvl_if lvl_bus ();

  logic live_mode;
  assign live_mode = mode_refreshes(op_mode_i);

  // cyclic operation replaces continuous refresh by the sample strobe
  assign lvl_bus.wake_pin = hv_wake_input_i;
  assign lvl_bus.gpio_pin = gpio_pin_i;
  assign lvl_bus.wake_sample = cyclic_active_i ? cyclic_sample_i : live_mode;
  // gpio level is never refreshed under cyclic sense
  assign lvl_bus.gpio_sample = live_mode && !cyclic_active_i;
  assign lvl_bus.wake_en = wake_enable_i;
  assign lvl_bus.gpio_en = gpio_has_level(gpio_cfg_i);
  assign lvl_bus.hv_meas = hv_measure_enable_i;

  wls_level_sampler u_level (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .lvl(lvl_bus.lvl)
  );

  // ****************************************
  // latched flags
  // ****************************************
  logic gpio_wake_ff;
  logic oc_ff;
  logic ol_ff;
  logic fail_out_ff;
  logic nxt_gpio_wake;
  logic nxt_oc;
  logic nxt_ol;
  logic nxt_fail_out;
  logic oc_event;
  logic ol_event;

  // overcurrent counts only for the switch config in use
  assign oc_event = switch_overcurrent_i && is_switch(gpio_cfg_i);
  assign ol_event = switch_open_load_i && (gpio_cfg_i == WLS_GPIO_HIGH_SIDE);

  // explicit clear strobe; a new event in the clearing cycle wins so it is never lost
  always_comb begin
    nxt_gpio_wake = gpio_wake_ff;
    nxt_oc = oc_ff;
    nxt_ol = ol_ff;
    if (reg_clear_i) begin
      unique case (reg_addr_i)
        WLS_ADDR_WAKE_SRC_1: nxt_gpio_wake = 1'b0;
        WLS_ADDR_SW_OVERCUR: nxt_oc = 1'b0;
        WLS_ADDR_SW_OPEN_LOAD: nxt_ol = 1'b0;
        default: ;
      endcase
    end
    if (gpio_wake_event_i && (gpio_cfg_i == WLS_GPIO_WAKE_IN)) begin
      nxt_gpio_wake = 1'b1;
    end
    // no config term on hold: flag survives reconfiguration
    if (oc_event) begin
      nxt_oc = 1'b1;
    end
    if (ol_event) begin
      nxt_ol = 1'b1;
    end
    // fail output level reported outside, not on the gpio level bit
    nxt_fail_out = (gpio_cfg_i == WLS_GPIO_FAIL_OUT) && gpio_pin_i;
  end

  // flag registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gpio_wake_ff <= 1'b0;
      oc_ff <= 1'b0;
      ol_ff <= 1'b0;
      fail_out_ff <= 1'b0;
    end else begin
      gpio_wake_ff <= nxt_gpio_wake;
      oc_ff <= nxt_oc;
      ol_ff <= nxt_ol;
      fail_out_ff <= nxt_fail_out;
    end
  end

  assign fail_output_failure_o = fail_out_ff;

  // ****************************************
  // read data
  // ****************************************

  // reserved positions stay at the zero reset pattern
  always_comb begin
    reg_rdata_o = WLS_RST_STATUS;
    unique case (reg_addr_i)
      WLS_ADDR_WAKE_SRC_1: reg_rdata_o[WLS_BIT_GPIO_WAKE] = gpio_wake_ff;
      WLS_ADDR_INPUT_LVL: begin
        reg_rdata_o[WLS_BIT_DEV_MODE] = development_mode_pin_state_i;
        reg_rdata_o[WLS_BIT_INT_PULLUP] = interrupt_pin_pullup_strap_i;
        reg_rdata_o[WLS_BIT_PIN_LEVEL] = lvl_bus.general_pin_level;
        reg_rdata_o[WLS_BIT_WAKE_LVL] = lvl_bus.wake_input_level;
      end
      WLS_ADDR_SW_OVERCUR: reg_rdata_o[WLS_BIT_OC] = oc_ff;
      WLS_ADDR_SW_OPEN_LOAD: reg_rdata_o[WLS_BIT_OL] = ol_ff;
      default: ;
    endcase
  end

endmodule : wls_status_regs

// ==== verif/wls_mcu_model.sv ====
/* controller model on the spi side: reads and clears status registers.
   assumes the bench calls its tasks from one sequence. */
`timescale 1ns/10ps
module wls_mcu_model
  import wls_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // register access
  output logic [6:0] reg_addr_o,
  output logic reg_clear_o,
  input wire logic [7:0] reg_rdata_i
);
  // ****
  // access tasks
  // ****
  // idle on an unmapped address so a stale read never looks valid
  initial begin
    reg_addr_o = 7'h7F;
    reg_clear_o = 1'b0;
  end
  // data is taken one edge after the address is set
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk_i) reg_addr_o <= a;
    @(posedge ref_clk_i) d = reg_rdata_i;
  endtask : rd
  // besides reset, flags only go away by this explicit clear
  task automatic clr(input logic [6:0] a);
    @(posedge ref_clk_i) begin
      reg_addr_o <= a;
      reg_clear_o <= 1'b1;
    end
    @(posedge ref_clk_i) reg_clear_o <= 1'b0;
  endtask : clr
endmodule : wls_mcu_model

// ==== verif/wls_status_regs_sva.sv ====
/* port assertions for the status registers.
   assumes one clock and an async active-low reset. */
`timescale 1ns/10ps
module wls_status_regs_sva
  import wls_pkg::*;
(
  // clock, reset, access
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_clear_i,
  input wire logic [7:0] reg_rdata_o,
  // state, pins, events
  input wire wls_mode_type op_mode_i,
  input wire wls_gpio_cfg_type gpio_cfg_i,
  input wire logic wake_enable_i,
  input wire logic cyclic_active_i,
  input wire logic cyclic_sample_i,
  input wire logic hv_measure_enable_i,
  input wire logic hv_wake_input_i,
  input wire logic gpio_pin_i,
  input wire logic development_mode_pin_state_i,
  input wire logic interrupt_pin_pullup_strap_i,
  input wire logic gpio_wake_event_i,
  input wire logic switch_overcurrent_i,
  input wire logic switch_open_load_i,
  input wire logic fail_output_failure_o
);
  // ****
  // assertions
  // ****
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // either switch config may latch overcurrent
  wire logic sw = gpio_cfg_i == WLS_GPIO_LOW_SIDE || gpio_cfg_i == WLS_GPIO_HIGH_SIDE;
  AST_WAKE_SET: assert property (
    gpio_wake_event_i && gpio_cfg_i == WLS_GPIO_WAKE_IN |=>
    reg_addr_i != WLS_ADDR_WAKE_SRC_1 || reg_rdata_o == 8'h10) else $error("wake flag");
  AST_OC_SET: assert property (
    switch_overcurrent_i && sw |=>
    reg_addr_i != WLS_ADDR_SW_OVERCUR || reg_rdata_o == 8'h40) else $error("oc flag");
  AST_OL_SET: assert property (
    switch_open_load_i && gpio_cfg_i == WLS_GPIO_HIGH_SIDE |=>
    reg_addr_i != WLS_ADDR_SW_OPEN_LOAD || reg_rdata_o == 8'h40) else $error("ol flag");
  AST_LVL_RSVD: assert property (
    reg_addr_i == WLS_ADDR_INPUT_LVL |-> (reg_rdata_o & 8'h2E) == 8'h00) else $error("rsvd");
  AST_STRAPS: assert property (
    reg_addr_i == WLS_ADDR_INPUT_LVL |-> reg_rdata_o[7:6] ==
    {development_mode_pin_state_i, interrupt_pin_pullup_strap_i}) else $error("straps");
  AST_HV_FORCE: assert property (
    hv_measure_enable_i |=> reg_addr_i != WLS_ADDR_INPUT_LVL ||
    (reg_rdata_o & 8'h11) == 8'h00) else $error("hv levels");
  AST_OC_HOLD: assert property (
    reg_addr_i == WLS_ADDR_SW_OVERCUR && reg_rdata_o[6] && !reg_clear_i |=>
    reg_addr_i != WLS_ADDR_SW_OVERCUR || reg_rdata_o[6]) else $error("oc lost");
  AST_FAIL_OUT: assert property (
    $past(rst_n_i) |-> fail_output_failure_o ==
    $past(gpio_cfg_i == WLS_GPIO_FAIL_OUT && gpio_pin_i)) else $error("fail out");
  AST_WAKE_LVL: assert property (
    op_mode_i == WLS_MODE_NORMAL && wake_enable_i && !cyclic_active_i && !hv_measure_enable_i
    |=> reg_addr_i != WLS_ADDR_INPUT_LVL || reg_rdata_o[0] == $past(hv_wake_input_i))
    else $error("wake level");
  cover property (gpio_wake_event_i);
  cover property (switch_overcurrent_i && sw);
  cover property (cyclic_sample_i && cyclic_active_i);
endmodule : wls_status_regs_sva
bind wls_status_regs wls_status_regs_sva i_sva (.ref_clk_i, .rst_n_i, .reg_addr_i,
  .reg_clear_i, .reg_rdata_o, .op_mode_i, .gpio_cfg_i, .wake_enable_i, .cyclic_active_i,
  .cyclic_sample_i, .hv_measure_enable_i, .hv_wake_input_i, .gpio_pin_i,
  .development_mode_pin_state_i, .interrupt_pin_pullup_strap_i, .gpio_wake_event_i,
  .switch_overcurrent_i, .switch_open_load_i, .fail_output_failure_o);

// ==== verif/tb_wls_status_regs.sv ====
/* bench: table of level cases, then flag and refresh tests.
   assumes the controller model drives address and clear. */
`timescale 1ns/10ps
module tb_wls_status_regs;
  import wls_pkg::*;
  // ****
  // stimulus and checks
  // ****
  typedef struct {wls_gpio_cfg_type c; logic [4:0] in; logic [7:0] x;} wls_row_type;
  logic ref_clk_i, rst_n_i, wen, cyc, smp, hv, wpin, gp, dev, strap, wev, oc, ol, clr, fail_q;
  logic [6:0] addr;
  logic [7:0] rdata;
  wls_mode_type op_mode_i;
  wls_gpio_cfg_type cfg;
  int fails, n_compared;
  // inputs are {wake pin, gpio pin, hv, dev, strap}
  wls_row_type rows [5] = '{'{WLS_GPIO_WAKE_IN, 5'b11000, 8'h11},
    '{WLS_GPIO_LOW_SIDE, 5'b01010, 8'h90}, '{WLS_GPIO_HIGH_SIDE, 5'b10001, 8'h41},
    '{WLS_GPIO_WAKE_IN, 5'b11111, 8'hC0}, '{WLS_GPIO_FAIL_OUT, 5'b01000, 8'h00}};
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  wls_mcu_model i_mcu (.ref_clk_i, .reg_addr_o(addr), .reg_clear_o(clr), .reg_rdata_i(rdata));
  wls_status_regs i_dut (.ref_clk_i, .rst_n_i, .reg_addr_i(addr), .reg_clear_i(clr),
    .reg_rdata_o(rdata), .op_mode_i, .gpio_cfg_i(cfg), .wake_enable_i(wen),
    .cyclic_active_i(cyc), .cyclic_sample_i(smp), .hv_measure_enable_i(hv),
    .hv_wake_input_i(wpin), .gpio_pin_i(gp), .development_mode_pin_state_i(dev),
    .interrupt_pin_pullup_strap_i(strap), .gpio_wake_event_i(wev),
    .switch_overcurrent_i(oc), .switch_open_load_i(ol), .fail_output_failure_o(fail_q));
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic rdc(input logic [6:0] a, input logic [7:0] x, input string n);
    logic [7:0] g;
    i_mcu.rd(a, g);
    chk(n, x, g);
  endtask : rdc
  // one-cycle event pulse: {gpio wake, overcurrent, open load}
  task automatic ev(input logic [2:0] e);
    @(posedge ref_clk_i) {wev, oc, ol} <= e;
    @(posedge ref_clk_i) {wev, oc, ol} <= 3'b000;
  endtask : ev
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial begin
    {rst_n_i, wen, cyc, smp, hv, wpin, gp, dev, strap, wev, oc, ol} = 12'h400;
    op_mode_i = WLS_MODE_NORMAL;
    cfg = WLS_GPIO_OFF;
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rdc(WLS_ADDR_WAKE_SRC_1, 8'h00, "wake_rst");
    rdc(WLS_ADDR_SW_OPEN_LOAD, 8'h00, "ol_rst");
    rdc(7'h50, 8'h00, "unmapped");
    foreach (rows[i]) begin
      @(posedge ref_clk_i) begin
        cfg <= rows[i].c;
        {wpin, gp, hv, dev, strap} <= rows[i].in;
      end
      rdc(WLS_ADDR_INPUT_LVL, rows[i].x, "level");
    end
    chk("fail_out", 8'h01, {7'h00, fail_q});
    // disabled wake input keeps its old level
    @(posedge ref_clk_i) begin
      wen <= 1'b0;
      wpin <= 1'b1;
    end
    rdc(WLS_ADDR_INPUT_LVL, 8'h00, "wake_off");
    @(posedge ref_clk_i) begin
      wen <= 1'b1;
      cyc <= 1'b1;
    end
    rdc(WLS_ADDR_INPUT_LVL, 8'h00, "cyc_hold");
    @(posedge ref_clk_i) smp <= 1'b1;
    @(posedge ref_clk_i) smp <= 1'b0;
    rdc(WLS_ADDR_INPUT_LVL, 8'h01, "cyc_smp");
    @(posedge ref_clk_i) cfg <= WLS_GPIO_WAKE_IN;
    ev(3'b100);
    @(posedge ref_clk_i) cfg <= WLS_GPIO_LOW_SIDE;
    ev(3'b011);
    rdc(WLS_ADDR_SW_OPEN_LOAD, 8'h00, "ol_ls");
    // reconfiguring must not drop latched flags
    @(posedge ref_clk_i) cfg <= WLS_GPIO_OFF;
    rdc(WLS_ADDR_SW_OVERCUR, 8'h40, "oc_kept");
    rdc(WLS_ADDR_WAKE_SRC_1, 8'h10, "wake_kept");
    i_mcu.clr(WLS_ADDR_SW_OVERCUR);
    rdc(WLS_ADDR_SW_OVERCUR, 8'h00, "oc_clr");
    @(posedge ref_clk_i) cfg <= WLS_GPIO_HIGH_SIDE;
    ev(3'b011);
    rdc(WLS_ADDR_SW_OVERCUR, 8'h40, "oc_hs");
    rdc(WLS_ADDR_SW_OPEN_LOAD, 8'h40, "ol_hs");
    // switch config under cyclic sense: gpio level must not follow the pin
    rdc(WLS_ADDR_INPUT_LVL, 8'h01, "gpio_cyc");
    // sleep is not a live mode, so both levels hold
    @(posedge ref_clk_i) begin
      op_mode_i <= WLS_MODE_SLEEP;
      cyc <= 1'b0;
      wpin <= 1'b0;
    end
    rdc(WLS_ADDR_INPUT_LVL, 8'h01, "sleep_hold");
    @(posedge ref_clk_i) op_mode_i <= WLS_MODE_STOP;
    rdc(WLS_ADDR_INPUT_LVL, 8'h10, "stop_live");
    i_mcu.clr(WLS_ADDR_WAKE_SRC_1);
    rdc(WLS_ADDR_WAKE_SRC_1, 8'h00, "wake_clr");
    i_mcu.clr(WLS_ADDR_SW_OPEN_LOAD);
    rdc(WLS_ADDR_SW_OPEN_LOAD, 8'h00, "ol_clr");
    // a clear aimed elsewhere leaves the overcurrent flag alone
    rdc(WLS_ADDR_SW_OVERCUR, 8'h40, "oc_other_clr");
    // event and clear in one cycle: the set wins
    fork
      i_mcu.clr(WLS_ADDR_SW_OPEN_LOAD);
      ev(3'b001);
    join
    rdc(WLS_ADDR_SW_OPEN_LOAD, 8'h40, "ol_set_wins");
    // reset in mid-run drops every latched flag
    @(posedge ref_clk_i) rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rdc(WLS_ADDR_SW_OVERCUR, 8'h00, "oc_rst");
    rdc(WLS_ADDR_SW_OPEN_LOAD, 8'h00, "ol_rst2");
    close_out();
  end
endmodule : tb_wls_status_regs
